// ### cpmr_core_state.v
// Core execution state, privilege checks, banked stack pointers and register file
// Functional notes
// (RL1) Two levels and two modes give three legal states; handler is always privileged.
// (RL2) Handler mode while an exception is serviced, thread mode otherwise.
// (RL3) Unprivileged access to restricted instructions, special, config or debug regions faults; only restricted_op_i is checked, data accesses never fault.
// (RL4) Privileged code may execute and access everything without a fault.
// (RL5) All sixteen core registers are 32 bits wide.
// (RL6) Registers zero to seven are reachable by short and long encodings.
// (RL7) Registers eight to twelve are reachable by long encodings, not by every short one; here every short encoding of them faults.
// (RL8) Only mixed 16-bit and 32-bit encodings are accepted; no legacy fixed-width state.
// (RL9) Separate main and process stack pointers are held.
// (RL10) The external reset input is active low and holds the block in reset while low.
// (RL11) Execution is split over three stages with separate instruction and data paths.
// (RL12) Bit-band alias accesses perform a single-bit read or write atomically.
// (RL13) Unaligned data accesses are accepted without an alignment fault.
// (RL14) A 4-GB space is split into code, data and peripheral regions on parallel buses; all data accesses here share one mem_addr_o port.
// (RL15) The process stack is used only in unprivileged thread mode when selected.
// (RL16) Control bit 0 selects thread privilege: zero privileged, one unprivileged.
// (RL17) After reset the core is in privileged thread mode on the main stack.
`include "cpmr_defines.vh"
module cpmr_core_state (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire external_reset_n_i,
  input wire exc_entry_i,
  input wire exc_return_i,
  input wire restricted_op_i,
  input wire instr_valid_i,
  input wire instr_enc_i,
  input wire instr_legacy_i,
  input wire rd_we_i,
  input wire [3:0] rd_idx_i,
  input wire [31:0] rd_data_i,
  input wire [3:0] rs_idx_i,
  input wire ctrl_we_i,
  input wire [1:0] ctrl_wdata_i,
  input wire sp_we_i,
  input wire [31:0] sp_wdata_i,
  input wire pc_we_i,
  input wire [31:0] pc_wdata_i,
  input wire dacc_valid_i,
  input wire dacc_we_i,
  input wire [31:0] dacc_addr_i,
  input wire [31:0] dacc_wdata_i,
  input wire [31:0] mem_rdata_i,
  output reg [31:0] rs_data_o,
  output reg [1:0] exec_state_o,
  output reg handler_mode_o,
  output reg privileged_o,
  output reg psp_active_o,
  output reg [31:0] main_stack_pointer_o,
  output reg [31:0] process_stack_pointer_o,
  output reg [31:0] pc_o,
  output reg fault_o,
  output reg core_reset_o,
  output reg mem_valid_o,
  output reg mem_we_o,
  output reg [31:0] mem_addr_o,
  output reg [31:0] mem_wdata_o,
  output reg [1:0] pipe_stage_o
);
  // Reset pin synchroniser
  reg external_reset_n_s1_r;
  reg external_reset_n_s2_r;
  wire rst_w;
  reg [1:0] ctrl_r;
  reg handler_r;
  reg [31:0] gpr_r [0:14];
  reg [31:0] msp_r;
  reg [31:0] psp_r;
  reg [31:0] pc_r;
  reg bb_pend_r;
  reg bb_we_r;
  reg [4:0] bb_bit_r;
  reg bb_val_r;
  reg [31:0] bb_word_r;
  reg [1:0] stage_r;
  reg [1:0] state_nxt;
  wire priv_w;
  wire use_psp_w;
  wire reg_ok_w;
  wire bb_hit_w;
  wire [31:0] bb_word_addr_w;
  wire [31:0] bb_off_w;
  integer i;

  // Encoding reach check
  function reg_reachable;
    input enc;
    input [3:0] idx;
    begin
      if (idx <= `CPMR_LOW_TOP) begin
        reg_reachable = 1'b1; // [RL6]
      end else if (enc == `CPMR_ENC32) begin
        reg_reachable = 1'b1; // [RL7]
      end else begin
        reg_reachable = (idx > `CPMR_HIGH_TOP); // [RL7]
      end
    end
  endfunction

  // Stack pointers are always word aligned
  function [31:0] sp_align;
    input [31:0] v;
    begin
      sp_align = {v[31:2], 2'h0}; // [RL9]
    end
  endfunction

  // Program counter is always half-word aligned
  function [31:0] pc_align;
    input [31:0] v;
    begin
      pc_align = {v[31:1], 1'b0};
    end
  endfunction

  always @(posedge core_clk_i) begin
    external_reset_n_s1_r <= external_reset_n_i;
    external_reset_n_s2_r <= external_reset_n_s1_r;
  end
  assign rst_w = sys_rst_i | ~external_reset_n_s2_r; // [RL10]

  assign priv_w = handler_r | ~ctrl_r[`CPMR_CTRL_NPRIV_BIT]; // [RL1] [RL16]
  assign use_psp_w = ~handler_r & ctrl_r[`CPMR_CTRL_NPRIV_BIT] &
    ctrl_r[`CPMR_CTRL_SPSEL_BIT]; // [RL15]
  assign reg_ok_w = reg_reachable(instr_enc_i, rd_idx_i) & reg_reachable(instr_enc_i, rs_idx_i);
  assign bb_off_w = dacc_addr_i - `CPMR_BB_ALIAS_BASE;
  assign bb_hit_w = (dacc_addr_i >= `CPMR_BB_ALIAS_BASE) &&
    (dacc_addr_i < `CPMR_BB_ALIAS_BASE + (`CPMR_BB_SIZE << 5)); // [RL12]
  assign bb_word_addr_w = `CPMR_BB_RGN_BASE + {5'h00, bb_off_w[31:7], 2'h0};

  always @* begin
    if (handler_r) begin
      state_nxt = `CPMR_ST_HANDLER; // [RL1]
    end else if (ctrl_r[`CPMR_CTRL_NPRIV_BIT]) begin
      state_nxt = `CPMR_ST_THREAD_USER;
    end else begin
      state_nxt = `CPMR_ST_THREAD_PRIV;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_w) begin
      ctrl_r <= `CPMR_CTRL_RST; // [RL17]
      handler_r <= 1'b0;
      msp_r <= 32'h0;
      psp_r <= 32'h0;
      pc_r <= 32'h0;
      fault_o <= 1'b0;
      stage_r <= 2'h0;
      bb_pend_r <= 1'b0;
      bb_we_r <= 1'b0;
      bb_bit_r <= 5'h00;
      bb_val_r <= 1'b0;
      bb_word_r <= 32'h0;
      mem_valid_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h0;
      mem_wdata_o <= 32'h0;
      rs_data_o <= 32'h0;
      for (i = 0; i < 15; i = i + 1) begin
        gpr_r[i] <= 32'h0;
      end
    end else begin
      fault_o <= 1'b0;
      // Three-stage fetch/decode/execute sequencing
      if (instr_valid_i) begin
        stage_r <= (stage_r == 2'h2) ? 2'h0 : stage_r + 2'h1; // [RL11]
      end
      if (exc_entry_i) begin
        handler_r <= 1'b1; // [RL2]
      end else if (exc_return_i) begin
        handler_r <= 1'b0; // [RL2]
      end
      if (instr_valid_i && (instr_legacy_i || !reg_ok_w)) begin
        fault_o <= 1'b1; // [RL8]
      end else if (restricted_op_i && !priv_w) begin
        fault_o <= 1'b1; // [RL3]
      end else begin
        if (ctrl_we_i && priv_w) begin
          // Stack select is written as zero by a control write in handler mode
          ctrl_r <= {ctrl_wdata_i[1] & ~handler_r, ctrl_wdata_i[0]}; // [RL4] [RL16]
        end
        if (instr_valid_i && rd_we_i) begin
          if (rd_idx_i == `CPMR_IDX_SP) begin
            if (use_psp_w) begin
              psp_r <= sp_align(rd_data_i); // [RL9]
            end else begin
              msp_r <= sp_align(rd_data_i); // [RL9]
            end
          end else if (rd_idx_i == `CPMR_IDX_PC) begin
            pc_r <= pc_align(rd_data_i);
          end else begin
            gpr_r[rd_idx_i] <= rd_data_i; // [RL5]
          end
        end
      end
      if (sp_we_i && !(instr_valid_i && rd_we_i && rd_idx_i == `CPMR_IDX_SP)) begin
        if (use_psp_w) begin
          psp_r <= sp_align(sp_wdata_i);
        end else begin
          msp_r <= sp_align(sp_wdata_i);
        end
      end
      if (pc_we_i) begin
        pc_r <= pc_align(pc_wdata_i);
      end
      if (rs_idx_i == `CPMR_IDX_SP) begin
        rs_data_o <= use_psp_w ? psp_r : msp_r;
      end else if (rs_idx_i == `CPMR_IDX_PC) begin
        rs_data_o <= pc_r;
      end else begin
        rs_data_o <= gpr_r[rs_idx_i];
      end
      // Data path: bit-band alias write becomes an atomic read-modify-write
      mem_valid_o <= 1'b0;
      mem_we_o <= 1'b0;
      if (bb_pend_r) begin
        bb_pend_r <= 1'b0;
        if (bb_we_r) begin
          mem_valid_o <= 1'b1;
          mem_we_o <= 1'b1;
          mem_addr_o <= bb_word_r;
          mem_wdata_o <= bb_val_r ? (mem_rdata_i | (32'h1 << bb_bit_r)) :
            (mem_rdata_i & ~(32'h1 << bb_bit_r)); // [RL12]
        end else begin
          mem_wdata_o <= {31'h0, mem_rdata_i[bb_bit_r]};
        end
      end else if (dacc_valid_i) begin
        mem_valid_o <= 1'b1;
        if (bb_hit_w) begin
          bb_pend_r <= 1'b1;
          bb_we_r <= dacc_we_i;
          bb_bit_r <= bb_off_w[6:2];
          bb_val_r <= dacc_wdata_i[0];
          bb_word_r <= bb_word_addr_w;
          mem_addr_o <= bb_word_addr_w; // [RL12]
        end else begin
          // Any byte address, aligned or not, is passed on unchanged
          mem_we_o <= dacc_we_i; // [RL13] [RL14]
          mem_addr_o <= dacc_addr_i;
          mem_wdata_o <= dacc_wdata_i;
        end
      end
    end
  end

  // Registered status outputs
  always @(posedge core_clk_i) begin
    if (rst_w) begin
      exec_state_o <= `CPMR_ST_THREAD_PRIV;
      handler_mode_o <= 1'b0;
      privileged_o <= 1'b1;
      psp_active_o <= 1'b0;
      main_stack_pointer_o <= 32'h0;
      process_stack_pointer_o <= 32'h0;
      pc_o <= 32'h0;
      core_reset_o <= 1'b1;
      pipe_stage_o <= 2'h0;
    end else begin
      exec_state_o <= state_nxt;
      handler_mode_o <= handler_r;
      privileged_o <= priv_w;
      psp_active_o <= use_psp_w;
      main_stack_pointer_o <= msp_r;
      process_stack_pointer_o <= psp_r;
      pc_o <= pc_r;
      core_reset_o <= 1'b0;
      pipe_stage_o <= stage_r;
    end
  end
endmodule // cpmr_core_state

// ### cpmr_defines.vh
// Constants for the core execution-state and register-file block
`ifndef CPMR_DEFINES_VH
`define CPMR_DEFINES_VH
`define CPMR_XLEN 32
`define CPMR_NREG 16
`define CPMR_RIDX_W 4
`define CPMR_IDX_SP 4'hd
`define CPMR_IDX_LR 4'he
`define CPMR_IDX_PC 4'hf
`define CPMR_LOW_TOP 4'h7
`define CPMR_HIGH_TOP 4'hc
`define CPMR_CTRL_NPRIV_BIT 0
`define CPMR_CTRL_SPSEL_BIT 1
`define CPMR_CTRL_RST 2'h0
`define CPMR_ST_THREAD_PRIV 2'h0
`define CPMR_ST_THREAD_USER 2'h1
`define CPMR_ST_HANDLER 2'h2
`define CPMR_ENC16 1'b0
`define CPMR_ENC32 1'b1
`define CPMR_BB_RGN_BASE 32'h20000000
`define CPMR_BB_ALIAS_BASE 32'h22000000
`define CPMR_BB_SIZE 32'h00100000
`endif

// ### cpmr_core_state_assertions.sv
// Concurrent checks on the execution-state and register-file block
`include "cpmr_defines.vh"
module cpmr_core_state_chk (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire external_reset_n_i,
  input wire instr_valid_i,
  input wire instr_enc_i,
  input wire instr_legacy_i,
  input wire rd_we_i,
  input wire [3:0] rd_idx_i,
  input wire dacc_valid_i,
  input wire dacc_we_i,
  input wire [31:0] dacc_addr_i,
  input wire [1:0] exec_state_o,
  input wire handler_mode_o,
  input wire privileged_o,
  input wire psp_active_o,
  input wire fault_o,
  input wire core_reset_o,
  input wire mem_valid_o,
  input wire mem_we_o,
  input wire [31:0] mem_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire bb_hit = dacc_addr_i[31:25] == 7'h11;
  property p_handler_priv;
    handler_mode_o |-> privileged_o && exec_state_o == `CPMR_ST_HANDLER;
  endproperty
  a_handler_priv: assert property (p_handler_priv) else $error("handler not privileged");
  property p_state_legal;
    exec_state_o != 2'h3;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("illegal state");
  property p_psp_user;
    psp_active_o |-> exec_state_o == `CPMR_ST_THREAD_USER;
  endproperty
  a_psp_user: assert property (p_psp_user) else $error("process stack outside user");
  property p_legacy;
    instr_valid_i && instr_legacy_i && !core_reset_o |=> fault_o;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy not faulted");
  property p_high_reg;
    instr_valid_i && !instr_enc_i && rd_we_i && rd_idx_i inside {[8:12]} && !core_reset_o
      |=> fault_o;
  endproperty
  a_high_reg: assert property (p_high_reg) else $error("short high reg not faulted");
  property p_ext_rst;
    !external_reset_n_i [*3] |=> core_reset_o;
  endproperty
  a_ext_rst: assert property (p_ext_rst) else $error("pin reset ignored");
  property p_rst_state;
    core_reset_o && $past(core_reset_o) |-> exec_state_o == `CPMR_ST_THREAD_PRIV && privileged_o;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("bad reset state");
  property p_bitband;
    dacc_valid_i && dacc_we_i && bb_hit && !mem_valid_o && !core_reset_o
      |=> mem_valid_o && !mem_we_o ##1 mem_valid_o && mem_we_o;
  endproperty
  a_bitband: assert property (p_bitband) else $error("bit-band sequence wrong");
  property p_unaligned;
    dacc_valid_i && !bb_hit && !mem_valid_o && !core_reset_o
      |=> mem_valid_o && mem_addr_o == $past(dacc_addr_i);
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("access address altered");
  c_handler: cover property (handler_mode_o);
  c_psp: cover property (psp_active_o);
  c_bb: cover property (mem_valid_o && mem_we_o);
endmodule // cpmr_core_state_chk
bind cpmr_core_state cpmr_core_state_chk u_chk (.*);

// ### cpu_privilege_mode_regs_bench.sv
// Self-checking bench for the execution-state and register-file block
module cpu_privilege_mode_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0, sys_rst_i = 1, external_reset_n_i = 1, exc_entry_i = 0, exc_return_i = 0;
  logic restricted_op_i = 0, instr_valid_i = 0, instr_enc_i = 0, instr_legacy_i = 0, rd_we_i = 0;
  logic ctrl_we_i = 0, sp_we_i = 0, pc_we_i = 0, dacc_valid_i = 0, dacc_we_i = 0;
  logic [3:0] rd_idx_i = 0, rs_idx_i = 0;
  logic [1:0] ctrl_wdata_i = 0, exec_state_o, pipe_stage_o;
  logic [31:0] rd_data_i = 0, sp_wdata_i = 0, pc_wdata_i = 0, dacc_addr_i = 0;
  logic [31:0] dacc_wdata_i = 0, mem_rdata_i = 0, rs_data_o, main_stack_pointer_o, pc_o;
  logic [31:0] process_stack_pointer_o, mem_addr_o, mem_wdata_o;
  logic handler_mode_o, privileged_o, psp_active_o, fault_o, core_reset_o, mem_valid_o, mem_we_o;
  int mismatches = 0;
  int num_checks = 0;
  cpmr_core_state dut (.*);
  always #10 core_clk_i = ~core_clk_i;
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic [1:0] s, input logic h, input logic p, input logic ps);
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(exec_state_o, s);
    chk(handler_mode_o, h);
    chk(privileged_o, p);
    chk(psp_active_o, ps);
  endtask
  task automatic instr(input logic enc, leg, rop, we, input logic [3:0] i,
                       input logic [31:0] d, input logic xf);
    @(posedge core_clk_i);
    {instr_valid_i, instr_enc_i, instr_legacy_i, restricted_op_i, rd_we_i} <= {1'b1, enc, leg, rop, we};
    rd_idx_i <= i;
    rd_data_i <= d;
    @(posedge core_clk_i);
    {instr_valid_i, instr_legacy_i, restricted_op_i, rd_we_i} <= 4'h0;
    rd_data_i <= ~d;
    @(negedge core_clk_i);
    chk(fault_o, xf);
  endtask
  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    @(posedge core_clk_i);
    rs_idx_i <= i;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(rs_data_o, e);
  endtask
  task automatic exc(input logic e);
    @(posedge core_clk_i);
    if (e) exc_entry_i <= 1;
    else exc_return_i <= 1;
    @(posedge core_clk_i);
    {exc_entry_i, exc_return_i} <= 2'h0;
  endtask
  task automatic ctrl(input logic [1:0] v);
    @(posedge core_clk_i);
    ctrl_we_i <= 1;
    ctrl_wdata_i <= v;
    @(posedge core_clk_i);
    ctrl_we_i <= 0;
  endtask
  task automatic sp(input logic [31:0] v);
    @(posedge core_clk_i);
    {sp_we_i, pc_we_i} <= 2'h3;
    sp_wdata_i <= v;
    pc_wdata_i <= v + 32'h0000_0002;
    @(posedge core_clk_i);
    {sp_we_i, pc_we_i} <= 2'h0;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(pc_o, {v[31:1] + 31'h1, 1'b0});
  endtask
  task automatic dacc(input logic we, input logic [31:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    {dacc_valid_i, dacc_we_i} <= {1'b1, we};
    dacc_addr_i <= a;
    dacc_wdata_i <= 32'h0000_0001;
    mem_rdata_i <= 32'h0000_0005;
    @(posedge core_clk_i);
    dacc_valid_i <= 0;
    @(negedge core_clk_i);
    chk({mem_valid_o, mem_we_o}, 2'h2);
    chk(mem_addr_o, e);
  endtask
  initial begin
    repeat (16) @(posedge core_clk_i);
    sys_rst_i <= 0;
    repeat (4) @(posedge core_clk_i);
    st(2'h0, 0, 1, 0);
    $display("test reset done");
    for (int i = 0; i < 13; i++) instr(1, 0, 0, 1, i[3:0], 32'h8765_4300 | i, 0);
    instr(0, 0, 0, 1, 4'h3, 32'hfedc_ba98, 0);
    instr(0, 0, 0, 1, 4'h9, 32'h1111_1111, 1);
    instr(1, 1, 0, 1, 4'h2, 32'h2222_2222, 1);
    for (int i = 0; i < 13; i++) rd(i[3:0], i == 3 ? 32'hfedc_ba98 : 32'h8765_4300 | i);
    chk(pipe_stage_o, 32'h1);
    $display("test registers done");
    exc(1);
    st(2'h2, 1, 1, 0);
    instr(1, 0, 1, 0, 4'h0, 0, 0);
    exc(0);
    st(2'h0, 0, 1, 0);
    sp(32'h2000_1003);
    chk(main_stack_pointer_o, 32'h2000_1000);
    ctrl(2'h3);
    st(2'h1, 0, 0, 1);
    instr(1, 0, 1, 0, 4'h0, 0, 1);
    ctrl(2'h0);
    st(2'h1, 0, 0, 1);
    sp(32'h2000_2007);
    chk(process_stack_pointer_o, 32'h2000_2004);
    chk(main_stack_pointer_o, 32'h2000_1000);
    exc(1);
    st(2'h2, 1, 1, 0);
    ctrl(2'h0);
    exc(0);
    st(2'h0, 0, 1, 0);
    $display("test modes done");
    dacc(1, 32'h2200_0004, 32'h2000_0000);
    @(negedge core_clk_i);
    chk({mem_valid_o, mem_we_o}, 2'h3);
    chk(mem_wdata_o, 32'h0000_0007);
    @(posedge core_clk_i);
    mem_rdata_i <= 32'hffff_fffa;
    dacc(0, 32'h2000_0101, 32'h2000_0101);
    $display("test memory done");
    @(posedge core_clk_i);
    external_reset_n_i <= 0;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(core_reset_o, 1);
    @(posedge core_clk_i);
    external_reset_n_i <= 1;
    repeat (5) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk(core_reset_o, 0);
    st(2'h0, 0, 1, 0);
    $display("test pin reset done");
    finish_test;
  end
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
endmodule // cpu_privilege_mode_regs_bench
